// ---- logic/plf_pkg.sv ----
// Purpose: Shared constants for the programmable logic functions block
// Assumes: 200 MHz clock, analogue values in 0.01 % steps, signed 16 bit
// Notes:   Register offsets are byte addresses on a 32-bit bus
package plf_pkg;

  // Analogue format: +/-100 % maps to +/-10000
  localparam int                 AN_W        = 16;
  localparam int                 AN_XW       = 18;
  localparam logic signed [17:0] FULL_POS    = 18'sh02710;
  localparam logic signed [17:0] FULL_NEG    = -18'sh02710;

  // Combiner operator codes
  localparam logic [3:0] OP_OFF      = 4'h0;
  localparam logic [3:0] OP_MIN      = 4'h1;
  localparam logic [3:0] OP_MAX      = 4'h2;
  localparam logic [3:0] OP_SUM      = 4'h3;
  localparam logic [3:0] OP_SUM_HALF = 4'h4;
  localparam logic [3:0] OP_AMB      = 4'h5;
  localparam logic [3:0] OP_AMB_HALF = 4'h6;
  localparam logic [3:0] OP_BMA      = 4'h7;
  localparam logic [3:0] OP_BMA_HALF = 4'h8;
  localparam logic [3:0] OP_ABS      = 4'h9;
  localparam logic [3:0] OP_ABS_HALF = 4'ha;

  // Expression operator codes and bracketing orders
  localparam logic [1:0] EOP_TERM = 2'h0;
  localparam logic [1:0] EOP_AND  = 2'h1;
  localparam logic [1:0] EOP_OR   = 2'h2;
  localparam logic [1:0] EOP_XOR  = 2'h3;
  localparam logic       ORDER_CHAINED = 1'b0;
  localparam logic       ORDER_PAIRED  = 1'b1;

  // Digital source list: 0 off, 1..8 inverters, 9 expression, 10.. external
  localparam int         SRC_W    = 5;
  localparam int         EXT_W    = 22;
  localparam logic [4:0] SRC_OFF  = 5'h00;
  localparam logic [4:0] SRC_INV1 = 5'h01;
  localparam logic [4:0] SRC_CMP1 = 5'h0a;
  localparam logic [4:0] SRC_CMP2 = 5'h0b;
  localparam logic [4:0] SRC_RUN  = 5'h0c;

  // Register offsets
  localparam logic [7:0] REG_COMB1_CFG = 8'h00;
  localparam logic [7:0] REG_COMB2_CFG = 8'h04;
  localparam logic [7:0] REG_INV_LO    = 8'h08;
  localparam logic [7:0] REG_INV_HI    = 8'h0c;
  localparam logic [7:0] REG_EXPR_SEL  = 8'h10;
  localparam logic [7:0] REG_EXPR_CFG  = 8'h14;
  localparam logic [7:0] REG_EXPR_DLY  = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1c;
  localparam logic [7:0] REG_COMB1_OUT = 8'h20;
  localparam logic [7:0] REG_COMB2_OUT = 8'h24;

  // Field positions
  localparam int CMB_SELA_LSB = 0;
  localparam int CMB_SELB_LSB = 2;
  localparam int CMB_OP_LSB   = 4;
  localparam int SEL_STRIDE   = 8;
  localparam int ECFG_ORD     = 0;
  localparam int ECFG_OP1_LSB = 1;
  localparam int ECFG_OP2_LSB = 3;
  localparam int ECFG_OP3_LSB = 5;

  // Writable bit masks
  localparam logic [31:0] MASK_COMB = 32'h0000_00ff;
  localparam logic [31:0] MASK_SEL  = 32'h1f1f_1f1f;
  localparam logic [31:0] MASK_ECFG = 32'h0000_007f;
  localparam logic [31:0] MASK_DLY  = 32'h0007_ffff;

  // Reset values
  localparam logic [31:0] RST_COMB     = 32'h0000_0004;
  localparam logic [31:0] RST_INV_LO   = 32'h0000_000b;
  localparam logic [31:0] RST_INV_HI   = 32'h0000_0000;
  localparam logic [31:0] RST_EXPR_SEL = 32'h000c_010a;
  localparam logic [31:0] RST_EXPR_CFG = 32'h0000_000a;
  localparam logic [31:0] RST_DLY      = 32'h0000_0000;

  // Set delay timing: 0.1 s steps up to 36000.0 s
  localparam longint      CLK_PERIOD_PS  = 5000;
  localparam longint      TENTH_PS       = 64'h0000_0017_4876_e800;
  localparam int          TENTH_CYCLES   = int'(TENTH_PS / CLK_PERIOD_PS);
  localparam logic [18:0] DLY_MAX_TENTHS = 19'h57e40;

endpackage

// ---- logic/plf_combiner.sv ----
// Purpose: One analogue combiner: clamp operands, apply operator, saturate
// Assumes: Operands chosen by the caller, same clock domain
// Notes:   Result registered; unknown operator codes give zero
`timescale 1ns/100ps
module plf_combiner
  import plf_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic signed [AN_W-1:0] firstOperand,
  input  wire logic signed [AN_W-1:0] secondOperand,
  input  wire logic        [3:0]      opSel,
  output      logic signed [AN_W-1:0] result
);

  function automatic logic signed [AN_XW-1:0] sat(input logic signed [AN_XW-1:0] x);
    sat = (x > FULL_POS) ? FULL_POS : ((x < FULL_NEG) ? FULL_NEG : x);
  endfunction

  logic signed [AN_XW-1:0] aC;
  logic signed [AN_XW-1:0] bC;
  logic signed [AN_XW-1:0] sum;
  logic signed [AN_XW-1:0] amb;
  logic signed [AN_XW-1:0] bma;
  logic signed [AN_XW-1:0] absD;
  logic signed [AN_XW-1:0] res_nxt;

  assign aC   = sat({{2{firstOperand[AN_W-1]}}, firstOperand});
  assign bC   = sat({{2{secondOperand[AN_W-1]}}, secondOperand});
  assign sum  = aC + bC;
  assign amb  = aC - bC;
  assign bma  = bC - aC;
  assign absD = amb[AN_XW-1] ? bma : amb;

  // Halved forms cannot leave the span, so need no clamp
  always_comb
  begin
    unique case (opSel)
      OP_OFF:      res_nxt = '0;
      OP_MIN:      res_nxt = (aC < bC) ? aC : bC;
      OP_MAX:      res_nxt = (aC > bC) ? aC : bC;
      OP_SUM:      res_nxt = sat(sum);
      OP_SUM_HALF: res_nxt = sum >>> 1;
      OP_AMB:      res_nxt = sat(amb);
      OP_AMB_HALF: res_nxt = amb >>> 1;
      OP_BMA:      res_nxt = sat(bma);
      OP_BMA_HALF: res_nxt = bma >>> 1;
      OP_ABS:      res_nxt = sat(absD);
      OP_ABS_HALF: res_nxt = absD >>> 1;
      default:     res_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      result <= '0;
    else
      result <= res_nxt[AN_W-1:0];
  end

endmodule

// ---- logic/plf_expr.sv ----
// Purpose: Four-input logic expression with two bracketing orders
// Assumes: Input bits already registered by the caller
// Notes:   A terminate operator ends the expression at its position
`timescale 1ns/100ps
module plf_expr
  import plf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] inBits,
  input  wire logic       orderSel,
  input  wire logic [1:0] operatorOne,
  input  wire logic [1:0] operatorTwo,
  input  wire logic [1:0] operatorThree,
  output      logic       exprRaw
);

  function automatic logic apply(input logic [1:0] op, input logic x, input logic y);
    unique case (op)
      EOP_AND: apply = x & y;
      EOP_OR:  apply = x | y;
      EOP_XOR: apply = x ^ y;
      default: apply = x;
    endcase
  endfunction

  logic firstPair;
  logic chained2;
  logic chained3;
  logic chainRes;
  logic secondPair;
  logic pairRes;

  assign firstPair  = apply(operatorOne, inBits[0], inBits[1]);
  assign chained2   = apply(operatorTwo, firstPair, inBits[2]);
  assign chained3   = apply(operatorThree, chained2, inBits[3]);
  assign chainRes   = (operatorOne == EOP_TERM) ? inBits[0] :
                      (operatorTwo == EOP_TERM) ? firstPair : chained3;
  assign secondPair = apply(operatorThree, inBits[2], inBits[3]);
  assign pairRes    = (operatorOne == EOP_TERM) ? inBits[0] :
                      apply(operatorTwo, firstPair, secondPair);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      exprRaw <= 1'b0;
    else
      exprRaw <= (orderSel == ORDER_PAIRED) ? pairRes : chainRes;
  end

endmodule

// ---- logic/plf_top.sv ----
// Purpose: Programmable logic functions: two analogue combiners, eight
//          inverters and one four-input logic expression, set over Wishbone
// Assumes: All inputs come from logic on the same clock
// Notes:   Digital outputs feed back into the source list one cycle late
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module plf_top
  import plf_pkg::*;
#(
  parameter int TENTH_CYCLES_P = TENTH_CYCLES
)
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output      logic [31:0]            wb_dat_o,
  output      logic                   wb_ack_o,
  input  wire logic signed [AN_W-1:0] analogueInputOne,
  input  wire logic signed [AN_W-1:0] analogueInputTwo,
  input  wire logic signed [AN_W-1:0] analogueInputThree,
  input  wire logic signed [AN_W-1:0] analogueInputFour,
  input  wire logic [EXT_W-1:0]       extSignals,
  output      logic signed [AN_W-1:0] analogueCombinerOne,
  output      logic signed [AN_W-1:0] analogueCombinerTwo,
  output      logic [7:0]             inverterOutputs,
  output      logic [3:0]             exprInputValues,
  output      logic                   exprOutput
);

  // Byte-lane merge shared by every writable register
  function automatic logic [31:0] mergeWord(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel,
                                            input logic [31:0] mask);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        m[i*8 +: 8] = wdat[i*8 +: 8];
    end
    mergeWord = m & mask;
  endfunction

  function automatic logic signed [AN_W-1:0] pickAnalogue(input logic [1:0] sel,
                                                          input logic signed [AN_W-1:0] a1,
                                                          input logic signed [AN_W-1:0] a2,
                                                          input logic signed [AN_W-1:0] a3,
                                                          input logic signed [AN_W-1:0] a4);
    unique case (sel)
      2'h0:    pickAnalogue = a1;
      2'h1:    pickAnalogue = a2;
      2'h2:    pickAnalogue = a3;
      default: pickAnalogue = a4;
    endcase
  endfunction

  // Configuration registers
  logic [31:0] comb1Cfg_r;
  logic [31:0] comb2Cfg_r;
  logic [31:0] invLo_r;
  logic [31:0] invHi_r;
  logic [31:0] exprSel_r;
  logic [31:0] exprCfg_r;
  logic [31:0] exprDly_r;
  logic [31:0] exprDly_nxt;

  // Bus decode
  logic        reqTaken;
  logic        wrTaken;
  logic [31:0] rdMux;
  logic [31:0] statusWord;

  assign reqTaken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrTaken  = reqTaken & wb_we_i;

  // Digital source list and selections
  logic [31:0]      srcVec;
  logic [63:0]      invSelWord;
  logic [SRC_W-1:0] invSel [8];
  logic [SRC_W-1:0] exprSel [4];
  logic [3:0]       exprIn_nxt;
  logic             exprRaw;

  assign srcVec     = {extSignals, exprOutput, inverterOutputs, 1'b0};
  assign invSelWord = {invHi_r, invLo_r};

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gInv
      assign invSel[g] = invSelWord[g*SEL_STRIDE +: SRC_W];
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          inverterOutputs[g] <= 1'b0;
        else
          inverterOutputs[g] <= ~srcVec[invSel[g]];
      end
    end
    for (g = 0; g < 4; g++)
    begin : gExprIn
      assign exprSel[g]    = exprSel_r[g*SEL_STRIDE +: SRC_W];
      assign exprIn_nxt[g] = srcVec[exprSel[g]];
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      exprInputValues <= 4'h0;
    else
      exprInputValues <= exprIn_nxt;
  end

  // Analogue combiners
  logic signed [AN_W-1:0] c1A;
  logic signed [AN_W-1:0] c1B;
  logic signed [AN_W-1:0] c2A;
  logic signed [AN_W-1:0] c2B;

  assign c1A = pickAnalogue(comb1Cfg_r[CMB_SELA_LSB +: 2], analogueInputOne,
                            analogueInputTwo, analogueInputThree, analogueInputFour);
  assign c1B = pickAnalogue(comb1Cfg_r[CMB_SELB_LSB +: 2], analogueInputOne,
                            analogueInputTwo, analogueInputThree, analogueInputFour);
  assign c2A = pickAnalogue(comb2Cfg_r[CMB_SELA_LSB +: 2], analogueInputOne,
                            analogueInputTwo, analogueInputThree, analogueInputFour);
  assign c2B = pickAnalogue(comb2Cfg_r[CMB_SELB_LSB +: 2], analogueInputOne,
                            analogueInputTwo, analogueInputThree, analogueInputFour);

  plf_combiner uComb1 (
    .clk           (clk),
    .arst_n        (arst_n),
    .firstOperand  (c1A),
    .secondOperand (c1B),
    .opSel         (comb1Cfg_r[CMB_OP_LSB +: 4]),
    .result        (analogueCombinerOne)
  );

  plf_combiner uComb2 (
    .clk           (clk),
    .arst_n        (arst_n),
    .firstOperand  (c2A),
    .secondOperand (c2B),
    .opSel         (comb2Cfg_r[CMB_OP_LSB +: 4]),
    .result        (analogueCombinerTwo)
  );

  // Logic expression
  plf_expr uExpr (
    .clk           (clk),
    .arst_n        (arst_n),
    .inBits        (exprInputValues),
    .orderSel      (exprCfg_r[ECFG_ORD]),
    .operatorOne   (exprCfg_r[ECFG_OP1_LSB +: 2]),
    .operatorTwo   (exprCfg_r[ECFG_OP2_LSB +: 2]),
    .operatorThree (exprCfg_r[ECFG_OP3_LSB +: 2]),
    .exprRaw       (exprRaw)
  );

  // Set delay: counts 0.1 s steps while the raw result is high.
  // Release is immediate; the reset delay is not part of this block.
  logic [24:0] preCnt_r;
  logic [18:0] tenthCnt_r;
  logic        preWrap;
  logic        delayDone;

  assign preWrap   = (preCnt_r == 25'(TENTH_CYCLES_P - 1));
  assign delayDone = (tenthCnt_r >= exprDly_r[18:0]);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      preCnt_r   <= '0;
      tenthCnt_r <= '0;
      exprOutput <= 1'b0;
    end
    else if (!exprRaw)
    begin
      preCnt_r   <= '0;
      tenthCnt_r <= '0;
      exprOutput <= 1'b0;
    end
    else if (!exprOutput)
    begin
      if (delayDone)
        exprOutput <= 1'b1;
      else if (preWrap)
      begin
        preCnt_r   <= '0;
        tenthCnt_r <= tenthCnt_r + 19'h00001;
      end
      else
        preCnt_r <= preCnt_r + 25'h0000001;
    end
  end

  // Delay written above the limit is held at the limit
  logic [31:0] dlyMerged;
  assign dlyMerged   = mergeWord(exprDly_r, wb_dat_i, wb_sel_i, MASK_DLY);
  assign exprDly_nxt = (dlyMerged[18:0] > DLY_MAX_TENTHS) ? {13'h0, DLY_MAX_TENTHS}
                                                          : dlyMerged;

  // Register writes; unmapped and read-only addresses match no strobe
  logic wrComb1;
  logic wrComb2;
  logic wrInvLo;
  logic wrInvHi;
  logic wrExprSel;
  logic wrExprCfg;
  logic wrExprDly;

  assign wrComb1   = wrTaken & (wb_adr_i == REG_COMB1_CFG);
  assign wrComb2   = wrTaken & (wb_adr_i == REG_COMB2_CFG);
  assign wrInvLo   = wrTaken & (wb_adr_i == REG_INV_LO);
  assign wrInvHi   = wrTaken & (wb_adr_i == REG_INV_HI);
  assign wrExprSel = wrTaken & (wb_adr_i == REG_EXPR_SEL);
  assign wrExprCfg = wrTaken & (wb_adr_i == REG_EXPR_CFG);
  assign wrExprDly = wrTaken & (wb_adr_i == REG_EXPR_DLY);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      comb1Cfg_r <= RST_COMB;
    else if (wrComb1)
      comb1Cfg_r <= mergeWord(comb1Cfg_r, wb_dat_i, wb_sel_i, MASK_COMB);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      comb2Cfg_r <= RST_COMB;
    else if (wrComb2)
      comb2Cfg_r <= mergeWord(comb2Cfg_r, wb_dat_i, wb_sel_i, MASK_COMB);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      invLo_r <= RST_INV_LO;
    else if (wrInvLo)
      invLo_r <= mergeWord(invLo_r, wb_dat_i, wb_sel_i, MASK_SEL);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      invHi_r <= RST_INV_HI;
    else if (wrInvHi)
      invHi_r <= mergeWord(invHi_r, wb_dat_i, wb_sel_i, MASK_SEL);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      exprSel_r <= RST_EXPR_SEL;
    else if (wrExprSel)
      exprSel_r <= mergeWord(exprSel_r, wb_dat_i, wb_sel_i, MASK_SEL);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      exprCfg_r <= RST_EXPR_CFG;
    else if (wrExprCfg)
      exprCfg_r <= mergeWord(exprCfg_r, wb_dat_i, wb_sel_i, MASK_ECFG);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      exprDly_r <= RST_DLY;
    else if (wrExprDly)
      exprDly_r <= exprDly_nxt;
  end

  // Read side; unmapped addresses read zero and ignore writes
  assign statusWord = {18'h0, inverterOutputs, exprOutput, exprRaw, exprInputValues};

  always_comb
  begin
    unique case (wb_adr_i)
      REG_COMB1_CFG: rdMux = comb1Cfg_r;
      REG_COMB2_CFG: rdMux = comb2Cfg_r;
      REG_INV_LO:    rdMux = invLo_r;
      REG_INV_HI:    rdMux = invHi_r;
      REG_EXPR_SEL:  rdMux = exprSel_r;
      REG_EXPR_CFG:  rdMux = exprCfg_r;
      REG_EXPR_DLY:  rdMux = exprDly_r;
      REG_STATUS:    rdMux = statusWord;
      REG_COMB1_OUT: rdMux = {{16{analogueCombinerOne[AN_W-1]}}, analogueCombinerOne};
      REG_COMB2_OUT: rdMux = {{16{analogueCombinerTwo[AN_W-1]}}, analogueCombinerTwo};
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  // One wait state: ack follows the taken request by one edge and drops next
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= reqTaken;
      if (reqTaken && !wb_we_i)
        wb_dat_o <= rdMux;
    end
  end

endmodule

// ---- test/plf_top_asserts.sv ----
// Purpose: Port-level assertions for the logic functions block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Config is invisible here, so checks stay on bus, ranges and defaults
`timescale 1ns/100ps
module plf_top_asserts
  import plf_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic signed [AN_W-1:0] analogueCombinerOne,
  input wire logic signed [AN_W-1:0] analogueCombinerTwo,
  input wire logic [7:0]             inverterOutputs,
  input wire logic                   exprOutput
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  wire logic rdTaken = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property ($rose(wb_ack_o) |=> $fell(wb_ack_o))
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_hold_a: assert property (!$past(rdTaken) |-> $stable(wb_dat_o))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (rdTaken && wb_adr_i >= 8'h28 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  comb1_range_a: assert property (analogueCombinerOne <= 16'sh2710 && analogueCombinerOne >= -16'sh2710)
    else $error("combiner one out of range");
  comb2_range_a: assert property (analogueCombinerTwo <= 16'sh2710 && analogueCombinerTwo >= -16'sh2710)
    else $error("combiner two out of range");
  comb_default_a: assert property ($rose(arst_n) |-> (analogueCombinerOne == 16'sh0 && analogueCombinerTwo == 16'sh0) [*2])
    else $error("combiner not off after reset");
  inv_default_a: assert property ($rose(arst_n) |=> inverterOutputs[7:1] == 7'h7f)
    else $error("inverter defaults wrong");

  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && !wb_we_i);
  cover property ($rose(exprOutput));
endmodule

// ---- test/plf_src_model.sv ----
// Purpose: Drive-side signal sources feeding the logic functions
// Assumes: Values change just after a rising clock edge
// Notes:   Behavioural; levels only, so no handshake to keep
`timescale 1ns/100ps
module plf_src_model
  import plf_pkg::*;
(
  input  wire logic                   clk,
  output      logic signed [AN_W-1:0] an1,
  output      logic signed [AN_W-1:0] an2,
  output      logic signed [AN_W-1:0] an3,
  output      logic signed [AN_W-1:0] an4,
  output      logic [EXT_W-1:0]       ext
);
  initial {an1, an2, an3, an4, ext} = '0;

  task automatic setAn(input logic signed [AN_W-1:0] v1, v2, v3, v4);
    @(posedge clk);
    {an1, an2, an3, an4} <= {v1, v2, v3, v4};
  endtask

  task automatic setExt(input logic [EXT_W-1:0] v);
    @(posedge clk);
    ext <= v;
  endtask
endmodule

// ---- test/plf_tb_top.sv ----
// Purpose: Self-checking bench for the logic functions block
// Assumes: Set delay tick shortened to 4 cycles per tenth
// Notes:   Expected values are worked out by hand from the operator rules
`timescale 1ns/100ps
module plf_tb_top
  import plf_pkg::*;
;
  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic                   wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0]             wbAdr = 8'h0;
  logic [3:0]             wbSel = 4'hf;
  logic [31:0]            wbDat = 32'h0;
  wire logic [31:0]       wbDatO;
  wire logic              wbAck, exprOut;
  wire logic signed [AN_W-1:0] an1, an2, an3, an4, comb1, comb2;
  wire logic [EXT_W-1:0]  ext;
  wire logic [7:0]        invOut;
  wire logic [3:0]        exprIn;
  int                     numErrors = 0;
  int                     checksDone = 0;
  logic [31:0] rstVal[7] = '{RST_COMB, RST_COMB, RST_INV_LO, RST_INV_HI, RST_EXPR_SEL,
                             RST_EXPR_CFG, RST_DLY};
  int          expOp[12] = '{0, -7000, 6000, -1000, -500, 10000, 6500, -10000, -6500,
                             10000, 6500, 0};
  logic [6:0]  exCfg[6] = '{7'h32, 7'h33, 7'h06, 7'h13, 7'h3c, 7'h0a};
  logic [3:0]  exIn[6] = '{4'h7, 4'h7, 4'h7, 4'h4, 4'h9, 4'h7};
  logic        exOut[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [31:0] rd;

  always #2.5 clk = ~clk;

  plf_src_model SRC (.clk(clk), .an1(an1), .an2(an2), .an3(an3), .an4(an4), .ext(ext));

  plf_top #(.TENTH_CYCLES_P(4)) DUT (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .analogueInputOne(an1), .analogueInputTwo(an2), .analogueInputThree(an3),
    .analogueInputFour(an4), .extSignals(ext), .analogueCombinerOne(comb1),
    .analogueCombinerTwo(comb2), .inverterOutputs(invOut), .exprInputValues(exprIn),
    .exprOutput(exprOut));

  task automatic closeOut;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    checksDone++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold the request until ack is sampled, then release for a cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'b11, we, adr, dat};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'b1);
    rd = wbDatO;
    {wbCyc, wbStb, wbWe} <= 3'b000;
    check("bus ack latency", 32'h2, 32'(n));
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check($sformatf("register %h", adr), exp, rd);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++)
      rdChk(8'(4 * i), rstVal[i]);
    rdChk(8'h28, 32'h0);
    check("inverter defaults", 32'hff, {24'h0, invOut});
    $display("test defaults done");

    // Inputs: 6000, -7000, 12000 (clamps to 10000), -3000
    SRC.setAn(16'sh1770, -16'sh1b58, 16'sh2ee0, -16'sh0bb8);
    for (int op = 0; op < 12; op++)
    begin
      wr(REG_COMB1_CFG, 32'(op * 16 + 4));
      repeat (2) @(posedge clk);
      check("combiner one", 32'(expOp[op]), 32'(comb1));
    end
    wr(REG_COMB2_CFG, {24'h0, OP_SUM_HALF, 4'he});
    repeat (2) @(posedge clk);
    check("combiner two", 32'h0dac, 32'(comb2));
    rdChk(REG_COMB2_OUT, 32'h0dac);
    $display("test combiners done");

    wr(REG_INV_HI, 32'h0000_000a);
    SRC.setExt(22'h3);
    repeat (2) @(posedge clk);
    check("inverters", 32'hee, {24'h0, invOut});
    $display("test inverters done");

    wr(REG_EXPR_SEL, 32'h0d0c_0b0a);
    for (int r = 0; r < 6; r++)
    begin
      wr(REG_EXPR_CFG, {25'h0, exCfg[r]});
      SRC.setExt({18'h0, exIn[r]});
      repeat (5) @(posedge clk);
      check("expression inputs", {28'h0, exIn[r]}, {28'h0, exprIn});
      check("expression", {31'h0, exOut[r]}, {31'h0, exprOut});
    end
    $display("test expression done");

    wr(REG_INV_HI, 32'h0900_000a);
    wr(REG_EXPR_DLY, 32'h7_ffff);
    rdChk(REG_EXPR_DLY, {13'h0, DLY_MAX_TENTHS});
    wr(REG_EXPR_DLY, 32'h2);
    SRC.setExt(22'h0);
    repeat (5) @(posedge clk);
    SRC.setExt(22'h7);
    repeat (11) @(posedge clk);
    check("delayed output early", 32'h0, {31'h0, exprOut});
    @(posedge clk);
    check("delayed output", 32'h1, {31'h0, exprOut});
    @(posedge clk);
    check("expression feedback", 32'h0, {31'h0, invOut[7]});
    SRC.setExt(22'h0);
    repeat (4) @(posedge clk);
    check("released output", 32'h0, {31'h0, exprOut});
    $display("test set delay done");
    closeOut();
  end

  // Whole sequence takes well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    numErrors++;
    closeOut();
  end
endmodule

bind plf_top plf_top_asserts CHK (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .analogueCombinerOne, .analogueCombinerTwo, .inverterOutputs,
  .exprOutput);
